// *** core/scd_top.sv ***
// serial master channel with a chained two-descriptor transfer engine
`timescale 1ns/100ps
`default_nettype none

module scd_top
#(
    parameter int HALF_CYCLES = scd_pkg::HALF_CYCLES,
    parameter int MAX_BURST   = scd_pkg::MAX_BURST
)
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    input  wire logic [19:0] i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_writedata,
    input  wire logic [3:0]  i_byteenable,
    output logic      [31:0] o_readdata,
    output logic             o_waitrequest,
    output logic             o_shift_clock_out,
    output logic             o_serial_data_out,
    input  wire logic        i_serial_data_in,
    output logic             o_irq
);

    // ======================================================================
    // state
    scd_pkg::scd_ctrl_type ctrl_r;
    scd_pkg::scd_dma_type  dma_r;
    logic        run_r;
    logic [7:0]  sdb_r;
    logic [4:0]  count_r;
    logic [4:0]  rx_ptr_r;
    logic [4:0]  tx_ptr_r;
    logic [1:0]  irq_stat_r;
    logic [1:0]  irq_mask_r;
    logic        ack_r;
    logic        ram_sel_r;
    logic [31:0] rd_r;
    logic        si_s1_r;
    logic        si_s2_r;
    logic        busy_r;
    logic        sck_r;
    logic        so_r;
    logic [2:0]  bit_r;
    logic [10:0] tmr_r;
    logic        end_evt_r;
    logic [7:0]  ram_rdata;

    // ======================================================================
    // bus decode
    wire         req        = i_read | i_write;
    wire         dma_idle   = (dma_r == scd_pkg::ST_IDLE);
    wire         grant      = req & ~ack_r & dma_idle & ~end_evt_r;
    wire         wr_go      = i_write & ack_r & i_byteenable[0];
    wire [7:0]   wbyte      = i_writedata[7:0];
    wire         hit_ctrl   = (i_address == scd_pkg::OFF_CTRL);
    wire         hit_start  = (i_address == scd_pkg::OFF_START);
    wire         hit_status = (i_address == scd_pkg::OFF_STATUS);
    wire         hit_sdb    = (i_address == scd_pkg::OFF_SDB);
    wire         hit_count  = (i_address == scd_pkg::OFF_COUNT);
    wire         hit_rxp    = (i_address == scd_pkg::OFF_RX_PTR);
    wire         hit_txp    = (i_address == scd_pkg::OFF_TX_PTR);
    wire         hit_ist    = (i_address == scd_pkg::OFF_IRQ_STAT);
    wire         hit_imk    = (i_address == scd_pkg::OFF_IRQ_MASK);
    wire         hit_ram    = (i_address >= scd_pkg::OFF_RAM_BASE)
                              && (i_address <= scd_pkg::OFF_RAM_LAST)
                              && (i_address[1:0] == 2'h0);
    wire [19:0]  ram_off    = i_address - scd_pkg::OFF_RAM_BASE;
    wire [4:0]   bus_ram_a  = ram_off[6:2];

    // unmapped reads return zero, unmapped writes are dropped
    wire [31:0]  rd_mux =
        hit_ctrl   ? {28'h0000000, ctrl_r} :
        hit_status ? {29'h00000000, ~dma_idle, busy_r, run_r} :
        hit_sdb    ? {24'h000000, sdb_r} :
        hit_count  ? {27'h0000000, count_r} :
        hit_rxp    ? {27'h0000000, rx_ptr_r} :
        hit_txp    ? {27'h0000000, tx_ptr_r} :
        hit_ist    ? {30'h00000000, irq_stat_r} :
        hit_imk    ? {30'h00000000, irq_mask_r} :
                     32'h00000000;

    assign o_waitrequest = req & ~ack_r;
    assign o_readdata    = ram_sel_r ? {24'h000000, ram_rdata} : rd_r;

    // ======================================================================
    // engine decisions
    // a burst size outside 2..16 means a count outside 1..15
    wire         cnt_ok     = (count_r >= 5'(scd_pkg::MIN_BURST - 1))
                              && (count_r <= 5'(MAX_BURST - 1));
    wire         en_wr      = wr_go & hit_ctrl & wbyte[3];
    wire         size_err   = en_wr & ~cnt_ok;
    // an enabled engine with transfers left takes the event itself
    wire         consume    = end_evt_r & ctrl_r.trig_en
                              & (count_r != 5'h00);
    wire         last_xfer  = (dma_r == scd_pkg::ST_TX_LD)
                              & (count_r == 5'h01);
    // untaken events and the exhausted count reach the processor
    wire         ev_set     = (end_evt_r & ~consume) | last_xfer;
    wire [1:0]   irq_set    = {size_err, ev_set};
    wire [1:0]   irq_clr    = (wr_go & hit_ist) ? wbyte[1:0] : 2'h0;
    wire         tx_load    = (dma_r == scd_pkg::ST_TX_LD);
    wire         sw_load    = wr_go & hit_sdb & run_r & ~busy_r;
    wire         shift_go   = tx_load | sw_load;

    // ======================================================================
    // memory port: the engine owns it while running
    wire         ram_we     = (dma_r == scd_pkg::ST_RX_WR)
                              | (dma_idle & wr_go & hit_ram);
    wire [4:0]   ram_a      = (dma_r == scd_pkg::ST_RX_WR) ? rx_ptr_r :
                              (dma_r == scd_pkg::ST_TX_RD) ? tx_ptr_r :
                              bus_ram_a;
    wire [7:0]   ram_wd     = (dma_r == scd_pkg::ST_RX_WR) ? sdb_r : wbyte;

    scd_ram #(
        .AW      (5)
    ) u_ram (
        .i_clk   (i_clk),
        .i_ce    (i_ce),
        .i_we    (ram_we),
        .i_addr  (ram_a),
        .i_wdata (ram_wd),
        .o_rdata (ram_rdata)
    );

    // ======================================================================
    // bus answer
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            ack_r     <= 1'b0;
            ram_sel_r <= 1'b0;
            rd_r      <= 32'h00000000;
        end
        else if (i_ce)
        begin
            ack_r <= grant;
            if (grant)
            begin
                ram_sel_r <= hit_ram;
                rd_r      <= rd_mux;
            end
        end
    end

    // ======================================================================
    // control registers
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            ctrl_r     <= scd_pkg::RST_CTRL;
            run_r      <= 1'b0;
            irq_mask_r <= scd_pkg::RST_IRQ;
        end
        else if (i_ce)
        begin
            if (wr_go & hit_ctrl)
            begin
                ctrl_r <= scd_pkg::scd_ctrl_type'(wbyte[3:0]);
                // a rejected size leaves the engine disarmed
                ctrl_r.trig_en <= wbyte[3] & cnt_ok;
            end
            else if (last_xfer)
            begin
                ctrl_r.trig_en <= 1'b0;
            end
            if (wr_go & hit_start & wbyte[scd_pkg::BIT_START])
            begin
                run_r <= 1'b1;
            end
            else if (wr_go & hit_start & wbyte[scd_pkg::BIT_STOP])
            begin
                run_r <= 1'b0;
            end
            if (wr_go & hit_imk)
            begin
                irq_mask_r <= wbyte[1:0];
            end
        end
    end

    // ======================================================================
    // interrupt status: a set in the clearing cycle wins
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            irq_stat_r <= scd_pkg::RST_IRQ;
        end
        else if (i_ce)
        begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    assign o_irq = |(irq_stat_r & irq_mask_r);

    // ======================================================================
    // chained descriptors
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            dma_r    <= scd_pkg::ST_IDLE;
            count_r  <= scd_pkg::RST_COUNT;
            rx_ptr_r <= scd_pkg::RST_RX_PTR;
            tx_ptr_r <= scd_pkg::RST_TX_PTR;
        end
        else if (i_ce)
        begin
            case (dma_r)
                scd_pkg::ST_IDLE:
                begin
                    if (consume)
                    begin
                        dma_r <= scd_pkg::ST_RX_WR;
                    end
                    else
                    begin
                        if (wr_go & hit_count)
                        begin
                            count_r <= wbyte[4:0];
                        end
                        if (wr_go & hit_rxp)
                        begin
                            rx_ptr_r <= wbyte[4:0];
                        end
                        if (wr_go & hit_txp)
                        begin
                            tx_ptr_r <= wbyte[4:0];
                        end
                    end
                end
                scd_pkg::ST_RX_WR:
                begin
                    // fixed source, incrementing destination
                    rx_ptr_r <= rx_ptr_r + 5'h01;
                    dma_r    <= scd_pkg::ST_TX_RD;
                end
                scd_pkg::ST_TX_RD:
                begin
                    dma_r <= scd_pkg::ST_TX_LD;
                end
                scd_pkg::ST_TX_LD:
                begin
                    tx_ptr_r <= tx_ptr_r + 5'h01;
                    count_r  <= count_r - 5'h01;
                    // one byte moved, no further descriptor
                    dma_r    <= scd_pkg::ST_IDLE;
                end
                default:
                begin
                    dma_r <= scd_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ======================================================================
    // serial input synchroniser
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            si_s1_r <= 1'b0;
            si_s2_r <= 1'b0;
        end
        else if (i_ce)
        begin
            si_s1_r <= i_serial_data_in;
            si_s2_r <= si_s1_r;
        end
    end

    // ======================================================================
    // shifter: clock low half drives a bit, rising edge samples
    wire         tmr_done = (tmr_r == 11'(HALF_CYCLES - 1));
    wire [7:0]   load_byte = tx_load ? ram_rdata : wbyte;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            busy_r    <= 1'b0;
            sck_r     <= 1'b1;
            so_r      <= 1'b0;
            bit_r     <= 3'h0;
            tmr_r     <= 11'h000;
            sdb_r     <= scd_pkg::RST_BYTE;
            end_evt_r <= 1'b0;
        end
        else if (i_ce)
        begin
            end_evt_r <= 1'b0;
            if (!busy_r)
            begin
                sck_r <= ctrl_r.idle_clk;
                if (shift_go)
                begin
                    busy_r <= 1'b1;
                    sdb_r  <= load_byte;
                    sck_r  <= 1'b0;
                    so_r   <= load_byte[7];
                    bit_r  <= 3'h0;
                    tmr_r  <= 11'h000;
                end
                else if (wr_go & hit_sdb)
                begin
                    sdb_r <= wbyte;
                end
                else if (!run_r)
                begin
                    so_r <= ctrl_r.idle_data;
                end
            end
            else if (!tmr_done)
            begin
                tmr_r <= tmr_r + 11'h001;
            end
            else
            begin
                tmr_r <= 11'h000;
                if (!sck_r)
                begin
                    // rising edge: take the input bit, msb first
                    sck_r <= 1'b1;
                    sdb_r <= {sdb_r[6:0], si_s2_r};
                end
                else if (bit_r == 3'(scd_pkg::CHAR_BITS - 1))
                begin
                    busy_r    <= 1'b0;
                    sck_r     <= ctrl_r.idle_clk;
                    end_evt_r <= 1'b1;
                end
                else
                begin
                    sck_r <= 1'b0;
                    so_r  <= sdb_r[7];
                    bit_r <= bit_r + 3'h1;
                end
            end
        end
    end

    // outputs rest at the idle levels while output is disabled
    assign o_shift_clock_out = ctrl_r.out_en ? sck_r : ctrl_r.idle_clk;
    assign o_serial_data_out = ctrl_r.out_en ? so_r : ctrl_r.idle_data;

endmodule
`default_nettype wire

// *** core/scd_pkg.sv ***
// constants, types and register map of the serial chain transfer engine
package scd_pkg;

    // ======================================================================
    // bus and register map
    localparam int          ADDR_W       = 20;
    localparam logic [19:0] OFF_CTRL     = 20'hFFF00;
    localparam logic [19:0] OFF_START    = 20'hFFF04;
    localparam logic [19:0] OFF_STATUS   = 20'hFFF08;
    localparam logic [19:0] OFF_SDB      = 20'hFFF10;
    localparam logic [19:0] OFF_COUNT    = 20'hFFF20;
    localparam logic [19:0] OFF_RX_PTR   = 20'hFFF24;
    localparam logic [19:0] OFF_TX_PTR   = 20'hFFF28;
    localparam logic [19:0] OFF_IRQ_STAT = 20'hFFF30;
    localparam logic [19:0] OFF_IRQ_MASK = 20'hFFF34;
    localparam logic [19:0] OFF_RAM_BASE = 20'hFE900;
    localparam logic [19:0] OFF_RAM_LAST = 20'hFE97C;

    // ======================================================================
    // field positions
    localparam int BIT_START   = 0;
    localparam int BIT_STOP    = 1;
    localparam int BIT_EV      = 0;
    localparam int BIT_ERR     = 1;
    localparam int ST_RUN      = 0;
    localparam int ST_BUSY     = 1;
    localparam int ST_DMA      = 2;

    // ======================================================================
    // reset values of the descriptors and control
    localparam logic [4:0] RST_RX_PTR = 5'h00;
    localparam logic [4:0] RST_TX_PTR = 5'h11;
    localparam logic [4:0] RST_COUNT  = 5'h03;
    localparam logic [1:0] RST_IRQ    = 2'h0;
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam int         MIN_BURST  = 2;
    localparam int         MAX_BURST  = 16;

    // ======================================================================
    // serial timing
    localparam int CLK_HZ        = 25000000;
    localparam int BIT_RATE_BPS  = 9600;
    localparam int HALF_CYCLES   = CLK_HZ / (2 * BIT_RATE_BPS);
    localparam int CHAR_BITS     = 8;

    // ======================================================================
    // types
    typedef struct packed {
        logic trig_en;
        logic idle_data;
        logic idle_clk;
        logic out_en;
    } scd_ctrl_type;

    localparam scd_ctrl_type RST_CTRL = 4'h0;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_RX_WR = 2'h1,
        ST_TX_RD = 2'h3,
        ST_TX_LD = 2'h2
    } scd_dma_type;

endpackage

// *** core/scd_ram.sv ***
// small byte memory holding the receive and transmit areas
`timescale 1ns/100ps
`default_nettype none
module scd_ram
#(
    parameter int AW = 5
)
(
    input  wire logic          i_clk,
    input  wire logic          i_ce,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [7:0]    i_wdata,
    output logic      [7:0]    o_rdata
);

    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge i_clk)
    begin
        if (i_ce)
        begin
            if (i_we)
            begin
                mem[i_addr] <= i_wdata;
            end
            o_rdata <= mem[i_addr];
        end
    end

endmodule
`default_nettype wire

// *** tb/scd_props.sv ***
// concurrent checks on the ports of the serial chain transfer engine
`timescale 1ns/100ps
`default_nettype none
module scd_props
#(
    parameter int HALF_CYCLES = 4,
    parameter int MAX_BURST   = 16
)
(
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_ce,
    input wire logic [19:0] i_address,
    input wire logic        i_read,
    input wire logic        i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0]  i_byteenable,
    input wire logic [31:0] o_readdata,
    input wire logic        o_waitrequest,
    input wire logic        o_shift_clock_out,
    input wire logic        o_serial_data_out,
    input wire logic        i_serial_data_in,
    input wire logic        o_irq
);
    // ======================================================================
    // helpers: length of the present clock level, falls in this frame
    logic        sck_q;
    logic [15:0] lvl_cnt;
    logic [4:0]  n_fall;
    wire         fell_sck = sck_q && !o_shift_clock_out;
    wire         idle_end = o_shift_clock_out && sck_q &&
                            lvl_cnt == 16'(HALF_CYCLES);

    // saturates so that long idle stretches never alias a half period
    always_ff @(posedge i_clk)
    begin
        sck_q <= o_shift_clock_out;
        if (i_rst)
            lvl_cnt <= 16'hFFFF;
        else if (o_shift_clock_out != sck_q)
            lvl_cnt <= 16'h0001;
        else if (lvl_cnt != 16'hFFFF)
            lvl_cnt <= lvl_cnt + 16'h0001;
        if (i_rst || idle_end)
            n_fall <= 5'h00;
        else if (fell_sck)
            n_fall <= n_fall + 5'h01;
    end

    // ======================================================================
    // assertions
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    chk_wait_first : assert property (
        $rose(i_read || i_write) |-> o_waitrequest)
        else $error("request answered without a wait cycle");
    chk_wait_bound : assert property (
        $rose(i_read || i_write) |-> ##[1:5] !o_waitrequest)
        else $error("request not answered within five cycles");
    chk_wait_idle : assert property (
        !(i_read || i_write) |-> !o_waitrequest)
        else $error("waitrequest high without a request");
    chk_low_half : assert property (
        o_shift_clock_out && !sck_q && lvl_cnt < 16'(2 * HALF_CYCLES)
        |-> lvl_cnt == 16'(HALF_CYCLES))
        else $error("shift clock low half has wrong length");
    chk_data_hold : assert property (
        o_shift_clock_out && sck_q && lvl_cnt < 16'(HALF_CYCLES)
        |-> $stable(o_serial_data_out))
        else $error("data out changed while shift clock high");
    chk_frame_bits : assert property (
        idle_end && n_fall != 5'h00 |-> n_fall == 5'h08)
        else $error("frame did not carry eight bits");
    chk_reset_quiet : assert property (
        $fell(i_rst) |-> !o_irq && !o_shift_clock_out && !o_serial_data_out)
        else $error("outputs not at reset levels");
    chk_read_byte : assert property (
        i_read && !o_waitrequest |-> o_readdata[31:8] == 24'h000000)
        else $error("read data above the low byte not zero");
endmodule

bind scd_top scd_props
#(
    .HALF_CYCLES (HALF_CYCLES),
    .MAX_BURST   (MAX_BURST)
)
u_props
(
    .i_clk             (i_clk),
    .i_rst             (i_rst),
    .i_ce              (i_ce),
    .i_address         (i_address),
    .i_read            (i_read),
    .i_write           (i_write),
    .i_writedata       (i_writedata),
    .i_byteenable      (i_byteenable),
    .o_readdata        (o_readdata),
    .o_waitrequest     (o_waitrequest),
    .o_shift_clock_out (o_shift_clock_out),
    .o_serial_data_out (o_serial_data_out),
    .i_serial_data_in  (i_serial_data_in),
    .o_irq             (o_irq)
);
`default_nettype wire

// *** tb/scd_slave.sv ***
// behavioural three-wire serial slave facing the channel
`timescale 1ns/100ps
`default_nettype none
module scd_slave
(
    input  wire logic i_clk,
    input  wire logic i_sck,
    input  wire logic i_mosi,
    output logic      o_miso
);
    logic [7:0] reply [0:15];
    logic [7:0] got   [0:15];
    logic [7:0] sh_out;
    logic [7:0] sh_in;
    int         n;
    int         nb;
    int         hold;

    initial
    begin
        n = 0;
        nb = 0;
        hold = 0;
        o_miso = 1'b0;
    end

    // type 1, msb first: next bit on the fall, capture on the rise
    always @(negedge i_sck)
    begin
        if (nb == 0)
            sh_out = reply[n[3:0]];
        o_miso = sh_out[7 - nb];
    end

    always @(posedge i_sck)
    begin
        sh_in = {sh_in[6:0], i_mosi};
        nb = nb + 1;
        if (nb == 8)
        begin
            got[n[3:0]] = sh_in;
            n = n + 1;
            nb = 0;
            hold = 3;
        end
    end

    // once the last bit has been held, the line no longer shows it
    always @(posedge i_clk)
    begin
        if (hold == 1)
            o_miso = ~o_miso;
        if (hold > 0)
            hold = hold - 1;
    end
endmodule
`default_nettype wire

// *** tb/scd_top_tb.sv ***
// self-checking bench of the serial chain transfer engine
`timescale 1ns/100ps
`default_nettype none
module scd_top_tb;
    typedef struct packed {
        logic [19:0] a;
        logic [7:0]  rst_v;
        logic [7:0]  wd;
        logic [3:0]  b;
        logic [7:0]  rb;
    } scd_row_type;

    // address, reset value, write data, byte enables, value read back
    localparam scd_row_type ROWS [0:7] = '{
        '{scd_pkg::OFF_COUNT,    8'h03, 8'h0F, 4'hF, 8'h0F},
        '{scd_pkg::OFF_RX_PTR,   8'h00, 8'h05, 4'hF, 8'h05},
        '{scd_pkg::OFF_TX_PTR,   8'h11, 8'h01, 4'h0, 8'h11},
        '{scd_pkg::OFF_IRQ_MASK, 8'h00, 8'h03, 4'hF, 8'h03},
        '{scd_pkg::OFF_IRQ_STAT, 8'h00, 8'h03, 4'hF, 8'h00},
        '{scd_pkg::OFF_STATUS,   8'h00, 8'h07, 4'hF, 8'h00},
        '{20'hFFF3C,             8'h00, 8'hFF, 4'hF, 8'h00},
        '{scd_pkg::OFF_CTRL,     8'h00, 8'h03, 4'hF, 8'h03}};

    logic        clk;
    logic        rst;
    logic [19:0] addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    logic        waitreq;
    logic        sck;
    logic        sdo;
    logic        sdi;
    logic        irq;
    int          mismatches;
    int          n_checks;
    int          cyc;

    scd_top #(.HALF_CYCLES(4)) uut
    (
        .i_clk             (clk),
        .i_rst             (rst),
        .i_ce              (1'b1),
        .i_address         (addr),
        .i_read            (rd),
        .i_write           (wr),
        .i_writedata       (wdata),
        .i_byteenable      (be),
        .o_readdata        (rdata),
        .o_waitrequest     (waitreq),
        .o_shift_clock_out (sck),
        .o_serial_data_out (sdo),
        .i_serial_data_in  (sdi),
        .o_irq             (irq)
    );

    scd_slave u_slv
    (
        .i_clk  (clk),
        .i_sck  (sck),
        .i_mosi (sdo),
        .o_miso (sdi)
    );

    always #20 clk = ~clk;

    // ======================================================================
    // reporting
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    // ======================================================================
    // bus and sequence tasks
    task automatic bus(input logic w, input logic [19:0] a,
                       input logic [31:0] d, input logic [3:0] b,
                       output logic [31:0] q);
        int t;
        t = 0;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        be <= b;
        rd <= !w;
        wr <= w;
        @(posedge clk);
        while (waitreq !== 1'b0 && t < 50)
        begin
            @(posedge clk);
            t++;
        end
        q = rdata;
        chk("waitrequest", 32'h00000000, {31'h0, waitreq});
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wr_reg(input logic [19:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hF, q);
    endtask

    task automatic rd_chk(input string what, input logic [19:0] a,
                          input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h00000000, 4'hF, q);
        chk($sformatf("%s at %h", what, a), exp, q);
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
    endtask

    task automatic wait_irq();
        int t;
        t = 0;
        while (irq !== 1'b1 && t < 3000)
        begin
            @(posedge clk);
            t++;
        end
        chk("interrupt", 32'h00000001, {31'h0, irq});
    endtask

    function automatic logic [7:0] txb(input int i);
        return 8'h3C ^ 8'(i * 23);
    endfunction

    function automatic logic [7:0] rxb(input int i);
        return 8'hA5 + 8'(i * 41);
    endfunction

    function automatic logic [19:0] ram(input int i);
        return scd_pkg::OFF_RAM_BASE + 20'(4 * i);
    endfunction

    task automatic row_pass();
        logic [31:0] q;
        for (int k = 0; k < 8; k++)
        begin
            rd_chk("reset value", ROWS[k].a, {24'h0, ROWS[k].rst_v});
            bus(1'b1, ROWS[k].a, {24'h0, ROWS[k].wd}, ROWS[k].b, q);
            rd_chk("read back", ROWS[k].a, {24'h0, ROWS[k].rb});
        end
        chk("idle clock level", 32'h00000001, {31'h0, sck});
    endtask

    task automatic burst(input int n);
        for (int i = 0; i < 16; i++)
        begin
            u_slv.reply[i] = rxb(i);
            wr_reg(ram(i), 32'h000000EE);
            wr_reg(ram(16 + i), {24'h0, txb(i)});
        end
        wr_reg(scd_pkg::OFF_COUNT, 32'(n - 1));
        wr_reg(scd_pkg::OFF_RX_PTR, 32'h00000000);
        wr_reg(scd_pkg::OFF_TX_PTR, 32'h00000011);
        wr_reg(scd_pkg::OFF_CTRL, 32'h0000000B);
        wr_reg(scd_pkg::OFF_IRQ_STAT, 32'h00000003);
        wr_reg(scd_pkg::OFF_IRQ_MASK, 32'h00000001);
        wr_reg(scd_pkg::OFF_START, 32'h00000001);
        u_slv.n = 0;
        // the idle clock was raised while programming, so realign the bits
        u_slv.nb = 0;
        wr_reg(scd_pkg::OFF_SDB, {24'h0, txb(0)});
        wait_irq();
        chk("frames at interrupt", 32'(n - 1), 32'(u_slv.n));
        rd_chk("trigger released", scd_pkg::OFF_CTRL, 32'h3);
        wr_reg(scd_pkg::OFF_IRQ_STAT, 32'h00000001);
        rd_chk("event cleared", scd_pkg::OFF_IRQ_STAT, 32'h0);
        wait_irq();
        chk("frames at end", 32'(n), 32'(u_slv.n));
        rd_chk("last byte", scd_pkg::OFF_SDB, {24'h0, rxb(n - 1)});
        for (int i = 0; i < n - 1; i++)
            rd_chk("stored byte", ram(i), {24'h0, rxb(i)});
        rd_chk("beyond count", ram(n - 1), 32'h000000EE);
        for (int i = 0; i < n; i++)
            chk("sent byte", {24'h0, txb(i)}, {24'h0, u_slv.got[i]});
        rd_chk("count", scd_pkg::OFF_COUNT, 32'h0);
        rd_chk("rx ptr", scd_pkg::OFF_RX_PTR, 32'(n - 1));
        rd_chk("tx ptr", scd_pkg::OFF_TX_PTR, 32'((n + 16) % 32));
    endtask

    // ======================================================================
    // main sequence
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        addr = 20'h00000;
        wdata = 32'h00000000;
        be = 4'h0;
        mismatches = 0;
        n_checks = 0;
        cyc = 0;
        do_reset();
        row_pass();
        // sizes below two and above sixteen bytes are refused
        for (int k = 0; k < 2; k++)
        begin
            wr_reg(scd_pkg::OFF_COUNT, k ? 32'h10 : 32'h0);
            wr_reg(scd_pkg::OFF_IRQ_MASK, k ? 32'h1 : 32'h3);
            wr_reg(scd_pkg::OFF_CTRL, 32'h0000000B);
            rd_chk("ctrl", scd_pkg::OFF_CTRL, 32'h3);
            rd_chk("size error", scd_pkg::OFF_IRQ_STAT, 32'h2);
            chk("masked irq", k ? 32'h0 : 32'h1, {31'h0, irq});
            wr_reg(scd_pkg::OFF_IRQ_STAT, 32'h00000002);
            rd_chk("error cleared", scd_pkg::OFF_IRQ_STAT, 32'h0);
            chk("irq cleared", 32'h0, {31'h0, irq});
        end
        burst(2);
        burst(4);
        burst(16);
        // reset in the middle of a frame
        wr_reg(scd_pkg::OFF_SDB, 32'h00000081);
        repeat (20) @(posedge clk);
        do_reset();
        row_pass();
        wrap_up();
    end
endmodule
`default_nettype wire
